// >>> src/apt_pkg.sv
// Package for the converter pair trigger and vector control block.
// Assumes one 200 MHz clock and a classic Wishbone slave with 32-bit data.
package apt_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_TABLE_BASE = 8'h00;
  localparam logic [7:0] ADDR_PIN_LOW    = 8'h04;
  localparam logic [7:0] ADDR_PIN_HIGH   = 8'h08;
  localparam logic [7:0] ADDR_PAIR_CTRL  = 8'h0c;
  localparam logic [7:0] ADDR_GLOBAL     = 8'h10;
  localparam logic [7:0] ADDR_READY      = 8'h14;

  // Field layout of the pair control register (per byte lane), plus the global trigger bit and the encoder shift
  localparam int SEL_LSB    = 0;
  localparam int SEL_MSB    = 4;
  localparam int SWTRG_BIT  = 5;
  localparam int PEND_BIT   = 6;
  localparam int IRQEN_BIT  = 7;
  localparam int GSW_BIT    = 0;
  localparam int ENC_SHIFT  = 2;

  // Trigger select codes
  localparam logic [4:0] TRG_OFF      = 5'h00;
  localparam logic [4:0] TRG_IND_SW   = 5'h01;
  localparam logic [4:0] TRG_GLOBAL   = 5'h02;
  localparam logic [4:0] TRG_SPECIAL  = 5'h03;
  localparam logic [4:0] TRG_PRI_LO   = 5'h04;
  localparam logic [4:0] TRG_PRI_HI   = 5'h0b;
  localparam logic [4:0] TRG_TMR1     = 5'h0c;
  localparam logic [4:0] TRG_SEC_SPEC = 5'h0d;
  localparam logic [4:0] TRG_SEC_LO   = 5'h0e;
  localparam logic [4:0] TRG_SEC_HI   = 5'h16;
  localparam logic [4:0] TRG_CL_LO    = 5'h17;
  localparam logic [4:0] TRG_CL_HI    = 5'h1e;
  localparam logic [4:0] TRG_TMR2     = 5'h1f;

  // Trigger event pulses from PWM generators and timers
  typedef struct packed {
    logic       tmr2;        // Timer 2 period match
    logic [7:0] pwm_cl;      // Current-limit triggers, generators 8..1
    logic [8:0] pwm_sec;     // Secondary triggers, generators 9..1
    logic       sec_special; // Secondary special event
    logic       tmr1;        // Timer 1 period match
    logic [7:0] pwm_pri;     // Primary triggers, generators 8..1
    logic       special;     // Primary special event
  } apt_trig_t;

  // Entire state of the control block
  typedef struct packed {
    logic [15:1]      base;
    logic [15:0]      pin_lo;
    logic [7:0]       pin_hi;
    logic [1:0][4:0]  trgsel;
    logic [1:0]       irq_en;
    logic [1:0]       pend;
    logic [1:0]       swtrg;
    logic [1:0]       issued;
    logic             gsw;
    logic             gsw_d;
    logic [6:0]       ready;
    logic             start;
    logic             start_pair;
    logic [1:0]       irq;
    logic             ack;
    logic [31:0]      dat;
  } apt_state_t;

endpackage : apt_pkg

// >>> src/apt_ctrl.sv
// Converter pair control: pin select, trigger select, pending tracking,
// pair interrupts and the vector read of the jump-table base.
// Assumes trigger inputs and converter answers come from logic on clk_i.
//
// Contract
// [R01] Table base stores bits 15..1; bit 0 reads zero.
// [R02] Reading table base returns stored base plus encoded ready term.
// [R03] Encoder picks lowest-numbered set ready flag; pair 0 ranks highest.
// [R04] Encoded pair number shifts left two bits before the add.
// [R05] Pin-select one: digital input enabled, converter mux tied to ground.
// [R06] Pin-select zero: analog mode, digital input off, pin is sampled.
// [R07] High pin-select register holds channels 16..23; upper byte reads zero.
// [R08] Pair interrupt enabled raises a request when that pair's conversion completes.
// [R09] Pending sets on selected trigger; reads zero once conversion completes.
// [R10] Software trigger starts pair; hardware clears it once pending sets.
// [R11] Software selects individual trigger code before setting software trigger.
// [R12] Requests wait while converter is busy, then proceed.
// [R13] Codes 0..3: off, individual, global, primary special event.
// [R14] Codes 4..11 primary PWM 1..8; code 12 timer 1.
// [R15] Code 13 secondary special; codes 14..22 secondary PWM 1..9.
// [R16] Codes 23..30 current-limit PWM 1..8; code 31 timer 2.
// [R17] First pair register: pair 1 in bits 15..8, pair 0 in bits 7..0.
// [R18] Ready flags set by hardware, cleared only by writing zero.
// [R19] Global trigger starts all global pairs; it never clears itself.
// [R20] With no ready flag set, vector read returns plain base.
// [R21] All writable controls reset to zero.
`timescale 1ns/1ps
module apt_ctrl #(
  parameter int NUM_READY = 7
) (
  input  wire logic                clk_i,       // System clock, 200 MHz
  input  wire logic                rst_i,       // Synchronous reset, active high
  input  wire logic                cyc_i,       // Wishbone cycle
  input  wire logic                stb_i,       // Wishbone strobe
  input  wire logic                we_i,        // Wishbone write
  input  wire logic [7:0]          adr_i,       // Wishbone byte address
  input  wire logic [3:0]          sel_i,       // Wishbone byte selects
  input  wire logic [31:0]         dat_i,       // Wishbone write data
  output logic      [31:0]         dat_o,       // Wishbone read data
  output logic                     ack_o,       // Wishbone acknowledge
  input  wire apt_pkg::apt_trig_t  trig_i,      // Trigger event pulses
  input  wire logic                conv_busy_i, // Converter resources busy
  input  wire logic [NUM_READY-1:0] conv_done_i, // Pair data in buffer, pulse
  output logic                     conv_start_o, // Start pulse to converter
  output logic                     conv_pair_o, // Pair being started
  output logic [1:0]               irq_o,       // Pair completion requests
  output logic [23:0]              pin_digital_o, // Digital read input enable
  output logic [23:0]              mux_ground_o  // Converter input tied to ground
);

  apt_pkg::apt_state_t st_reg;
  apt_pkg::apt_state_t st_next;

  logic        wr_en;
  logic [31:0] src_vec;
  logic [1:0]  trig_hit;
  logic [2:0]  enc_idx;
  logic        enc_any;
  logic [15:0] vector_val;
  logic [15:0] pair_word;
  logic [31:0] rd_val;

  // Write takes effect on the edge where the master sees ack
  assign wr_en = cyc_i && stb_i && we_i && st_reg.ack;

  // Source vector indexed by the select code; bit 1 is handled per pair
  always_comb begin
    src_vec = '0;
    src_vec[apt_pkg::TRG_GLOBAL]  = st_reg.gsw && !st_reg.gsw_d; // R19
    src_vec[apt_pkg::TRG_SPECIAL] = trig_i.special;                // R13
    src_vec[apt_pkg::TRG_PRI_HI:apt_pkg::TRG_PRI_LO] = trig_i.pwm_pri; // R14
    src_vec[apt_pkg::TRG_TMR1]     = trig_i.tmr1;                 // R14
    src_vec[apt_pkg::TRG_SEC_SPEC] = trig_i.sec_special;          // R15
    src_vec[apt_pkg::TRG_SEC_HI:apt_pkg::TRG_SEC_LO] = trig_i.pwm_sec; // R15
    src_vec[apt_pkg::TRG_CL_HI:apt_pkg::TRG_CL_LO]   = trig_i.pwm_cl;  // R16
    src_vec[apt_pkg::TRG_TMR2]     = trig_i.tmr2;                 // R16
  end

  // Per-pair trigger decode; code zero never fires
  for (genvar p = 0; p < 2; p++) begin : g_pair
    always_comb begin
      if (st_reg.trgsel[p] == apt_pkg::TRG_IND_SW) begin
        trig_hit[p] = st_reg.swtrg[p];                              // R10
      end else if (st_reg.trgsel[p] == apt_pkg::TRG_OFF) begin
        trig_hit[p] = 1'b0;                                         // R13
      end else begin
        trig_hit[p] = src_vec[st_reg.trgsel[p]];
      end
    end
  end

  // Priority encoder: the lowest pair number wins
  always_comb begin
    enc_idx = '0;
    enc_any = 1'b0;
    for (int i = NUM_READY - 1; i >= 0; i--) begin
      if (st_reg.ready[i]) begin
        enc_idx = i[2:0];                                           // R03
        enc_any = 1'b1;
      end
    end
  end

  // Vector value: base with bit 0 zero plus the shifted pair number
  assign vector_val = {st_reg.base, 1'b0}
                    + (enc_any ? {11'h000, enc_idx, 2'b00} : 16'h0000); // R02 R04 R20

  // Pair control word as software sees it
  assign pair_word = {st_reg.irq_en[1], st_reg.pend[1], st_reg.swtrg[1], st_reg.trgsel[1],
                      st_reg.irq_en[0], st_reg.pend[0], st_reg.swtrg[0], st_reg.trgsel[0]}; // R17

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    case (adr_i)
      apt_pkg::ADDR_TABLE_BASE: rd_val = {16'h0000, vector_val};           // R01 R02
      apt_pkg::ADDR_PIN_LOW:    rd_val = {16'h0000, st_reg.pin_lo};
      apt_pkg::ADDR_PIN_HIGH:   rd_val = {24'h000000, st_reg.pin_hi};      // R07
      apt_pkg::ADDR_PAIR_CTRL:  rd_val = {16'h0000, pair_word};
      apt_pkg::ADDR_GLOBAL:     rd_val = {31'h0, st_reg.gsw};
      apt_pkg::ADDR_READY:      rd_val = {25'h0, st_reg.ready};
      default:                  rd_val = 32'h00000000;
    endcase
  end

  // Next-state logic for the whole block
  always_comb begin
    st_next = st_reg;
    st_next.start = 1'b0;
    st_next.irq   = 2'b00;
    st_next.gsw_d = st_reg.gsw;

    // Bus answer: one ack per request, dropped the cycle after
    st_next.ack = cyc_i && stb_i && !st_reg.ack;
    if (cyc_i && stb_i && !st_reg.ack && !we_i) begin
      st_next.dat = rd_val;
    end

    // Register writes, honouring byte selects
    if (wr_en) begin
      case (adr_i)
        apt_pkg::ADDR_TABLE_BASE: begin
          if (sel_i[0]) st_next.base[7:1] = dat_i[7:1];            // R01
          if (sel_i[1]) st_next.base[15:8] = dat_i[15:8];
        end
        apt_pkg::ADDR_PIN_LOW: begin
          if (sel_i[0]) st_next.pin_lo[7:0] = dat_i[7:0];
          if (sel_i[1]) st_next.pin_lo[15:8] = dat_i[15:8];
        end
        apt_pkg::ADDR_PIN_HIGH: begin
          if (sel_i[0]) st_next.pin_hi = dat_i[7:0];               // R07
        end
        apt_pkg::ADDR_PAIR_CTRL: begin
          for (int p = 0; p < 2; p++) begin
            if (sel_i[p]) begin                                     // R17
              st_next.trgsel[p] = dat_i[8*p+apt_pkg::SEL_MSB -: 5];
              st_next.irq_en[p] = dat_i[8*p+apt_pkg::IRQEN_BIT];
              st_next.swtrg[p]  = dat_i[8*p+apt_pkg::SWTRG_BIT];
            end
          end
        end
        apt_pkg::ADDR_GLOBAL: begin
          if (sel_i[0]) st_next.gsw = dat_i[apt_pkg::GSW_BIT];     // R19
        end
        apt_pkg::ADDR_READY: begin
          // Only writing zero clears a flag; ones are ignored
          if (sel_i[0]) st_next.ready = st_reg.ready & dat_i[NUM_READY-1:0]; // R18
        end
        default: begin
        end
      endcase
    end

    // Completion: ready set wins over a software clear
    st_next.ready = st_next.ready | conv_done_i;                    // R18
    for (int p = 0; p < 2; p++) begin
      if (conv_done_i[p]) begin
        st_next.pend[p]   = 1'b0;                                   // R09
        st_next.issued[p] = 1'b0;
        st_next.irq[p]    = st_reg.irq_en[p];                       // R08
      end
      // A new trigger wins over a completion in the same cycle
      if (trig_hit[p]) begin
        st_next.pend[p] = 1'b1;                                     // R09
      end
      // Software trigger clears itself once pending is set
      if (st_reg.pend[p] && st_reg.swtrg[p] &&
          st_reg.trgsel[p] == apt_pkg::TRG_IND_SW) begin
        st_next.swtrg[p] = 1'b0;                                    // R10
      end
    end

    // Issue: a pending pair waits until the converter is free
    if (!conv_busy_i && !st_reg.start) begin                        // R12
      if (st_reg.pend[0] && !st_reg.issued[0]) begin
        st_next.start      = 1'b1;
        st_next.start_pair = 1'b0;
        st_next.issued[0]  = 1'b1;
      end else if (st_reg.pend[1] && !st_reg.issued[1]) begin
        st_next.start      = 1'b1;
        st_next.start_pair = 1'b1;
        st_next.issued[1]  = 1'b1;
      end
    end
  end

  // State register; everything resets to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;                                                 // R21
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state
  assign dat_o        = st_reg.dat;
  assign ack_o        = st_reg.ack;
  assign conv_start_o = st_reg.start;
  assign conv_pair_o  = st_reg.start_pair;
  assign irq_o        = st_reg.irq;
  // Digital mode and grounded mux share one bit per pin
  assign pin_digital_o = {st_reg.pin_hi, st_reg.pin_lo};            // R05 R06
  assign mux_ground_o  = {st_reg.pin_hi, st_reg.pin_lo};            // R05 R06

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_base_bit0;
    cyc_i && stb_i && !we_i && !st_reg.ack && adr_i == apt_pkg::ADDR_TABLE_BASE
      |=> ack_o && dat_o[0] == 1'b0 && dat_o[1] == st_reg.base[1];
  endproperty
  a_base_bit0: assert property (p_base_bit0) // R01
    else $error("table base read bit 0 not zero");

  property p_vector;
    cyc_i && stb_i && !we_i && !st_reg.ack && adr_i == apt_pkg::ADDR_TABLE_BASE
      && st_reg.ready[0]
      |=> dat_o[15:0] == {st_reg.base, 1'b0};
  endproperty
  a_vector: assert property (p_vector) // R03
    else $error("pair 0 ready must encode as zero");

  // Encoder picks a set flag with no set flag below it; low sum bits untouched
  property p_enc_shift;
    enc_any |-> vector_val[1:0] == {st_reg.base[1], 1'b0} && st_reg.ready[enc_idx]
      && (st_reg.ready & ((7'h01 << enc_idx) - 7'h01)) == 7'h00;
  endproperty
  a_enc_shift: assert property (p_enc_shift) // R03 R04
    else $error("encoded term wrong");

  property p_no_ready;
    st_reg.ready == '0 |-> vector_val == {st_reg.base, 1'b0};
  endproperty
  a_no_ready: assert property (p_no_ready) // R20
    else $error("empty ready must add zero");

  property p_irq;
    conv_done_i[0] |=> irq_o[0] == $past(st_reg.irq_en[0]) ##1 !irq_o[0];
  endproperty
  a_irq: assert property (p_irq) // R08
    else $error("pair 0 interrupt wrong");

  property p_pend;
    trig_hit[1] |=> st_reg.pend[1];
  endproperty
  a_pend: assert property (p_pend) // R09
    else $error("pending not set by trigger");

  property p_swclr;
    st_reg.pend[0] && st_reg.swtrg[0] && st_reg.trgsel[0] == apt_pkg::TRG_IND_SW
      && !(wr_en && adr_i == apt_pkg::ADDR_PAIR_CTRL) |=> !st_reg.swtrg[0];
  endproperty
  a_swclr: assert property (p_swclr) // R10
    else $error("software trigger not cleared");

  property p_busy_hold;
    conv_busy_i |=> !conv_start_o;
  endproperty
  a_busy_hold: assert property (p_busy_hold) // R12
    else $error("start issued while busy");

  property p_ready_sticky;
    st_reg.ready[2] && !(wr_en && adr_i == apt_pkg::ADDR_READY) |=> st_reg.ready[2];
  endproperty
  a_ready_sticky: assert property (p_ready_sticky) // R18
    else $error("ready flag lost");

  property p_gsw_hold;
    st_reg.gsw && !(wr_en && adr_i == apt_pkg::ADDR_GLOBAL) |=> st_reg.gsw;
  endproperty
  a_gsw_hold: assert property (p_gsw_hold) // R19
    else $error("global trigger cleared itself");

  property p_pin_hi;
    cyc_i && stb_i && !we_i && !st_reg.ack && adr_i == apt_pkg::ADDR_PIN_HIGH
      |=> dat_o[31:8] == 24'h000000 && pin_digital_o[23:16] == dat_o[7:0];
  endproperty
  a_pin_hi: assert property (p_pin_hi) // R07
    else $error("high pin register upper bits not zero");

endmodule : apt_ctrl

// >>> testbench/apt_conv_model.sv
// Converter model: answers each start pulse with a done pulse later.
// Assumes starts come one at a time from the control block on clk_i.
`timescale 1ns/1ps
module apt_conv_model (
  input  wire logic       clk_i,   // System clock
  input  wire logic       rst_i,   // Synchronous reset
  input  wire logic       start_i, // Start pulse
  input  wire logic       pair_i,  // Pair being started
  input  wire logic [7:0] delay_i, // Conversion length in cycles
  input  wire logic [6:0] extra_i, // Extra done pulses from the bench
  output logic            busy_o,  // Conversion in progress
  output logic [6:0]      done_o   // Data in buffer pulses
);
  logic [7:0] cnt_reg;
  logic       pair_reg;

  // Busy from start to done, so the block must hold later requests
  always_ff @(posedge clk_i) begin
    done_o <= extra_i;
    if (rst_i) begin
      busy_o  <= 1'b0;
      cnt_reg <= 8'h00;
    end else if (start_i) begin
      busy_o   <= 1'b1;
      cnt_reg  <= delay_i;
      pair_reg <= pair_i;
    end else if (busy_o && cnt_reg <= 8'h01) begin
      busy_o           <= 1'b0;
      done_o[pair_reg] <= 1'b1;
    end else if (busy_o) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule : apt_conv_model

// >>> testbench/testbench.sv
// Self-checking bench for the pair trigger and vector control block.
// Assumes the converter model file is compiled before this one.
`timescale 1ns/1ps
module testbench;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]         adr = 8'h00, delay = 8'h04;
  logic [3:0]         sel = 4'h3;
  logic [31:0]        wdat = 32'h0, rdat, q;
  logic               ack, busy, start, pair, busy_q = 1'b0;
  logic [6:0]         done, extra = 7'h00;
  logic [1:0]         irq;
  logic [23:0]        pin_dig, mux_gnd;
  apt_pkg::apt_trig_t trig = '0;
  int                 error_cnt = 0, num_checks = 0, irq_c0 = 0, irq_c1 = 0;
  logic [15:0]        b, lo, hi;
  logic [6:0]         r, m;
  int                 c0, c1;

  apt_ctrl apt_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .trig_i(trig), .conv_busy_i(busy), .conv_done_i(done), .conv_start_o(start),
    .conv_pair_o(pair), .irq_o(irq), .pin_digital_o(pin_dig), .mux_ground_o(mux_gnd));
  apt_conv_model apt_conv_model_i (.clk_i(clk_i), .rst_i(rst_i), .start_i(start),
    .pair_i(pair), .delay_i(delay), .extra_i(extra), .busy_o(busy), .done_o(done));

  always #2.5 clk_i = ~clk_i;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // Classic single cycle; released at the edge where ack is seen, or after 40 edges without ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (n >= 40) check("ack", 0, 1);
  endtask : wb

  task automatic pulse(input logic [28:0] mk);
    @(posedge clk_i);
    trig <= apt_pkg::apt_trig_t'(mk);
    @(posedge clk_i);
    trig <= '0;
  endtask : pulse

  // Polls the ready flags; a bounded wait, never a fixed guess
  task automatic wait_rdy(input logic [6:0] mk);
    int n;
    n = 0;
    do begin
      wb(1'b0, apt_pkg::ADDR_READY, 32'h0);
      n++;
    end while ((q[6:0] & mk) !== mk && n < 40);
    check("ready", q[6:0] & mk, mk);
  endtask : wait_rdy

  // Expected vector read: base with bit 0 dropped plus first ready pair times four
  function automatic logic [31:0] vec(input logic [15:0] bs, input logic [6:0] rf);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 6; i >= 0; i--) begin
      if (rf[i]) v = 16'(i) << 2;
    end
    return {16'h0000, (bs & 16'hfffe) + v};
  endfunction : vec

  // Starts must never follow a busy cycle; pair requests are counted
  always @(posedge clk_i) begin
    if (start === 1'b1) check("start_busy", busy_q, 0);
    busy_q <= busy;
    irq_c0 += (irq[0] === 1'b1);
    irq_c1 += (irq[1] === 1'b1);
  end

  initial begin
    #(5 * 30000);
    check("watchdog", 0, 1);
    wrap_up();
  end

  initial begin
    void'($urandom(32'hbaaa));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      wb(1'b0, 8'(a * 4), 32'h0);
      check("reset_reg", q, 0);
    end
    check("reset_pins", pin_dig, 0);
    check("reset_mux", mux_gnd, 0);
    $display("test reset done");
    // The last base written stays in b for the encoder test
    for (int k = 0; k < 5; k++) begin
      b = (k == 0) ? 16'hffff : 16'($urandom);
      wb(1'b1, apt_pkg::ADDR_TABLE_BASE, {16'h0, b});
      wb(1'b0, apt_pkg::ADDR_TABLE_BASE, 32'h0);
      check("base", q, vec(b, 7'h00));
    end
    $display("test base done");
    repeat (4) begin
      lo = 16'($urandom);
      hi = 16'($urandom);
      wb(1'b1, apt_pkg::ADDR_PIN_LOW, {16'h0, lo});
      wb(1'b1, apt_pkg::ADDR_PIN_HIGH, {16'h0, hi});
      wb(1'b0, apt_pkg::ADDR_PIN_HIGH, 32'h0);
      check("pin_high", q, {24'h0, hi[7:0]});
      check("pin_dig", pin_dig, {hi[7:0], lo});
      check("mux_gnd", mux_gnd, {hi[7:0], lo});
      wb(1'b0, apt_pkg::ADDR_PIN_LOW, 32'h0);
      check("pin_low", q, {16'h0, lo});
    end
    $display("test pins done");
    for (int c = 0; c < 32; c++) begin
      if (c == 1 || c == 2) continue;
      delay <= 8'($urandom_range(1, 8));
      wb(1'b1, apt_pkg::ADDR_PAIR_CTRL, 32'(c));
      pulse(c == 0 ? '1 : 29'h1 << ((c - 2) % 29));
      repeat (12) @(posedge clk_i);
      wb(1'b0, apt_pkg::ADDR_READY, 32'h0);
      check("stray", q, 0);
      if (c > 0) begin
        pulse(29'h1 << (c - 3));
        wait_rdy(7'h01);
        wb(1'b0, apt_pkg::ADDR_PAIR_CTRL, 32'h0);
        check("pend_done", q[6], 0);
        wb(1'b1, apt_pkg::ADDR_READY, 32'h0);
      end
    end
    $display("test codes done");
    for (int i = 0; i < 10; i++) begin
      r = (i < 2) ? 7'(i * 64) : 7'($urandom);
      m = 7'($urandom);
      @(posedge clk_i);
      extra <= r;
      @(posedge clk_i);
      extra <= 7'h00;
      wb(1'b0, apt_pkg::ADDR_TABLE_BASE, 32'h0);
      check("vector", q, vec(b, r));
      wb(1'b1, apt_pkg::ADDR_READY, {25'h0, m});
      wb(1'b0, apt_pkg::ADDR_READY, 32'h0);
      check("ready_clr", q, {25'h0, r & m});
      wb(1'b1, apt_pkg::ADDR_READY, 32'h0);
    end
    $display("test encoder done");
    c0 = irq_c0;
    c1 = irq_c1;
    delay <= 8'd30;
    wb(1'b1, apt_pkg::ADDR_PAIR_CTRL, 32'h8183);
    pulse(29'h1);
    wb(1'b1, apt_pkg::ADDR_PAIR_CTRL, 32'ha183);
    repeat (2) @(posedge clk_i);
    wb(1'b0, apt_pkg::ADDR_PAIR_CTRL, 32'h0);
    check("soft_trig", q[15:13], 3'b110);
    wait_rdy(7'h03);
    check("irq1", irq_c1 - c1, 1);
    check("irq0", irq_c0 - c0, 1);
    $display("test soft done");
    delay <= 8'd4;
    wb(1'b1, apt_pkg::ADDR_READY, 32'h0);
    wb(1'b1, apt_pkg::ADDR_PAIR_CTRL, 32'h0202);
    wb(1'b1, apt_pkg::ADDR_GLOBAL, 32'h1);
    wait_rdy(7'h03);
    wb(1'b1, apt_pkg::ADDR_READY, 32'h0);
    wb(1'b1, apt_pkg::ADDR_GLOBAL, 32'h1);
    repeat (20) @(posedge clk_i);
    wb(1'b0, apt_pkg::ADDR_READY, 32'h0);
    check("global_hold", q, 0);
    wb(1'b1, apt_pkg::ADDR_GLOBAL, 32'h0);
    wb(1'b1, apt_pkg::ADDR_GLOBAL, 32'h1);
    wait_rdy(7'h03);
    $display("test global done");
    wrap_up();
  end
endmodule : testbench
